// File: rtl/mccu_defs.svh
`ifndef MCCU_DEFS_SVH
`define MCCU_DEFS_SVH

// Register byte offsets
`define MCCU_OFS_BASE 8'h00
`define MCCU_OFS_SHIFT 8'h04
`define MCCU_OFS_STATUS 8'h08
`define MCCU_OFS_MASK 8'h0C
`define MCCU_OFS_FLAGS 8'h10
`define MCCU_OFS_COUNT 8'h14
`define MCCU_OFS_SEQ 8'h18
`define MCCU_OFS_ADDR 8'h1C

// Interrupt status and mask bit positions
`define MCCU_IRQ_DEVICE 0
`define MCCU_IRQ_OVERFLOW 1
`define MCCU_IRQ_OUTSIDE 2

// Flag readback bit positions
`define MCCU_FLG_OUTSIDE 0
`define MCCU_FLG_SHARED1 1
`define MCCU_FLG_SHARED2 2
`define MCCU_FLG_PRIV1 3
`define MCCU_FLG_PRIV2 4
`define MCCU_FLG_PRIV3 5
`define MCCU_FLG_READ_DONE 6
`define MCCU_FLG_OVERFLOW 7
`define MCCU_FLG_LOW_BIT 8

// Reset values
`define MCCU_RST_MASK 3'h0
`define MCCU_RST_FLAGS 9'h000

// AXI response codes
`define MCCU_RESP_OKAY 2'h0
`define MCCU_RESP_SLVERR 2'h2

`endif

// File: rtl/mccu_pkg.sv
package mccu_pkg;

	typedef enum logic [1:0] {
		MCCU_SEQ_NEXT = 2'b00,
		MCCU_SEQ_OUT_OF_SEQUENCE_OP = 2'b01,
		MCCU_SEQ_JUMP = 2'b11
	} mccu_seq_t;

	typedef enum logic [2:0] {
		MCCU_IO_NONE = 3'h0,
		MCCU_IO_RD1 = 3'h1,
		MCCU_IO_RD2 = 3'h2,
		MCCU_IO_WR1 = 3'h3,
		MCCU_IO_WR2 = 3'h4
	} mccu_io_t;

	typedef enum logic [1:0] {
		MCCU_CNT_NONE = 2'h0,
		MCCU_CNT_INC = 2'h1,
		MCCU_CNT_LOAD = 2'h2
	} mccu_cnt_t;

	typedef enum logic [3:0] {
		MCCU_TST_NONE = 4'h0,
		MCCU_TST_OUTSIDE = 4'h1,
		MCCU_TST_SHARED1 = 4'h2,
		MCCU_TST_SHARED2 = 4'h3,
		MCCU_TST_PRIV1 = 4'h4,
		MCCU_TST_PRIV2 = 4'h5,
		MCCU_TST_PRIV3 = 4'h6,
		MCCU_TST_READ_DONE = 4'h7,
		MCCU_TST_OVERFLOW = 4'h8,
		MCCU_TST_LOW_BIT = 4'h9
	} mccu_test_t;

	typedef enum logic [1:0] {
		MCCU_SRC_CONST = 2'h0,
		MCCU_SRC_SHIFT_COMP = 2'h1,
		MCCU_SRC_COUNTER = 2'h2
	} mccu_src_t;

	// Set bits: [0] shared one, [1] shared two, [2..4] private one..three
	typedef struct packed {
		mccu_seq_t seq;
		mccu_io_t io;
		mccu_cnt_t cnt;
		mccu_test_t test;
		mccu_src_t adder_src;
		logic [4:0] set_flags;
		logic const_load;
		logic addr_load;
		logic alt_load;
		logic shift_comp_load;
		logic shift_left;
		logic adder_used;
	} mccu_uop_t;

endpackage

// File: rtl/mccu_top.sv
`include "mccu_defs.svh"

// Functional notes
// - Device read uses base one or two
// - Device write uses base one or two
// - Out-of-sequence op runs alternate plus one
// - Outside event set externally, cleared on test
// - Shared flags set by op, kept on test
// - Count-up increments counter, sets overflow flag
// - Interrupt on locked unselected device request
// - Jump to alternate plus one, load counter
// - Left shift end-off, zero fill
// - Three private flags set, cleared on test
// - Counter load takes complemented constant, clears overflow
// - Constant loadable, feeds adder, address, counter
// - Address load copies constant to address
// - Low-bit condition is previous adder LSB
// - Complemented shift amount usable as source
// - Read complete set externally, cleared on test
module mccu_top import mccu_pkg::*; #(
	parameter int DATA_W = 16,
	parameter int UADDR_W = 12,
	parameter int SHIFT_W = 4,
	parameter int DEV_N = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic uop_valid,
	input wire mccu_uop_t uop,
	input wire logic [DATA_W-1:0] const_value,
	input wire logic [UADDR_W-1:0] alt_value,
	input wire logic [DATA_W-1:0] adder_result,
	input wire logic outside_event_pin,
	input wire logic read_ready_pin,
	input wire logic [DEV_N-1:0] dev_locked_pin,
	input wire logic [DEV_N-1:0] dev_service_pin,
	input wire logic [DEV_N-1:0] dev_selected,
	output logic [UADDR_W-1:0] next_uaddr,
	output logic branch_taken,
	output logic dev_read_stb,
	output logic dev_write_stb,
	output logic [DATA_W-1:0] dev_base,
	output logic [DATA_W-1:0] shifter_out,
	output logic [DATA_W-1:0] adder_operand,
	output logic [DATA_W-1:0] memory_address_reg,
	output logic irq,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// Pin synchronisers: first stage is read only by the second
	logic [1+2*DEV_N:0] sync_a;
	logic [1+2*DEV_N:0] sync_b;
	logic outside_prev;
	logic ready_prev;

	// Software-visible state
	logic [15:0] base_reg_one;
	logic [15:0] base_reg_two;
	logic [SHIFT_W-1:0] shift_amount_reg;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;

	// Sequencing and datapath state
	logic [UADDR_W-1:0] sequence_counter;
	logic [UADDR_W-1:0] alternate_sequence_counter;
	logic [DATA_W-1:0] constant_field_reg;
	logic [DATA_W-1:0] loop_counter;
	logic counter_overflow_flag;
	logic adder_low_bit_cond;
	logic outside_event_flag;
	logic shared_flag_one;
	logic shared_flag_two;
	logic private_flag_one;
	logic private_flag_two;
	logic private_flag_three;
	logic read_complete_flag;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync_a <= '0;
			sync_b <= '0;
			outside_prev <= 1'b0;
			ready_prev <= 1'b0;
		end else begin
			sync_a <= {dev_service_pin, dev_locked_pin, read_ready_pin, outside_event_pin};
			sync_b <= sync_a;
			outside_prev <= sync_b[0];
			ready_prev <= sync_b[1];
		end
	end

	wire outside_set = sync_b[0] & ~outside_prev;
	wire ready_set = sync_b[1] & ~ready_prev;
	wire [DEV_N-1:0] locked_s = sync_b[2 +: DEV_N];
	wire [DEV_N-1:0] service_s = sync_b[2+DEV_N +: DEV_N];
	wire dev_irq_event = |(locked_s & service_s & ~dev_selected);

	// Microinstruction decode
	wire run = uop_valid;
	wire [UADDR_W-1:0] alt_plus_one = alternate_sequence_counter + UADDR_W'(1);
	wire [UADDR_W-1:0] seq_plus_one = sequence_counter + UADDR_W'(1);
	wire [DATA_W-1:0] shift_comp = {{(DATA_W-SHIFT_W){1'b0}}, ~shift_amount_reg};
	wire [DATA_W:0] count_sum = {1'b0, loop_counter} + {{DATA_W{1'b0}}, 1'b1};

	// Tested flag value is taken before the clear lands
	logic test_value;
	always_comb begin
		unique case (uop.test)
			MCCU_TST_NONE: test_value = 1'b1;
			MCCU_TST_OUTSIDE: test_value = outside_event_flag;
			MCCU_TST_SHARED1: test_value = shared_flag_one;
			MCCU_TST_SHARED2: test_value = shared_flag_two;
			MCCU_TST_PRIV1: test_value = private_flag_one;
			MCCU_TST_PRIV2: test_value = private_flag_two;
			MCCU_TST_PRIV3: test_value = private_flag_three;
			MCCU_TST_READ_DONE: test_value = read_complete_flag;
			MCCU_TST_OVERFLOW: test_value = counter_overflow_flag;
			MCCU_TST_LOW_BIT: test_value = adder_low_bit_cond;
			default: test_value = 1'b0;
		endcase
	end

	wire taken = run & test_value;
	wire tst_outside = run & (uop.test == MCCU_TST_OUTSIDE);
	wire tst_priv1 = run & (uop.test == MCCU_TST_PRIV1);
	wire tst_priv2 = run & (uop.test == MCCU_TST_PRIV2);
	wire tst_priv3 = run & (uop.test == MCCU_TST_PRIV3);
	wire tst_ready = run & (uop.test == MCCU_TST_READ_DONE);
	wire [4:0] set_req = run ? uop.set_flags : 5'h00;

	// Sequencing only deviates when the test passes
	wire do_out_of_sequence_op = taken & (uop.seq == MCCU_SEQ_OUT_OF_SEQUENCE_OP);
	wire do_jump = taken & (uop.seq == MCCU_SEQ_JUMP);
	wire [UADDR_W-1:0] next_addr_w = (do_out_of_sequence_op | do_jump) ? alt_plus_one : seq_plus_one;
	wire [UADDR_W-1:0] next_seq_w = do_out_of_sequence_op ? sequence_counter : next_addr_w;

	wire io_rd = taken & ((uop.io == MCCU_IO_RD1) | (uop.io == MCCU_IO_RD2));
	wire io_wr = taken & ((uop.io == MCCU_IO_WR1) | (uop.io == MCCU_IO_WR2));
	wire io_two = (uop.io == MCCU_IO_RD2) | (uop.io == MCCU_IO_WR2);
	wire [DATA_W-1:0] base_sel = DATA_W'(io_two ? base_reg_two : base_reg_one);

	wire cnt_inc = taken & (uop.cnt == MCCU_CNT_INC);
	wire cnt_load = taken & (uop.cnt == MCCU_CNT_LOAD);

	logic [DATA_W-1:0] operand_w;
	always_comb begin
		unique case (uop.adder_src)
			MCCU_SRC_CONST: operand_w = constant_field_reg;
			MCCU_SRC_SHIFT_COMP: operand_w = shift_comp;
			MCCU_SRC_COUNTER: operand_w = loop_counter;
			default: operand_w = '0;
		endcase
	end

	wire [DATA_W-1:0] shift_w = uop.shift_left ? (adder_result << shift_amount_reg) : adder_result;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sequence_counter <= '0;
			alternate_sequence_counter <= '0;
			next_uaddr <= '0;
			branch_taken <= 1'b0;
			dev_read_stb <= 1'b0;
			dev_write_stb <= 1'b0;
			dev_base <= '0;
			shifter_out <= '0;
			adder_operand <= '0;
		end else begin
			if (run) begin
				sequence_counter <= next_seq_w;
				next_uaddr <= next_addr_w;
				branch_taken <= taken;
				shifter_out <= shift_w;
				adder_operand <= operand_w;
			end
			if (run & uop.alt_load)
				alternate_sequence_counter <= alt_value;
			dev_read_stb <= io_rd;
			dev_write_stb <= io_wr;
			if (io_rd | io_wr)
				dev_base <= base_sel;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			constant_field_reg <= '0;
			memory_address_reg <= '0;
			loop_counter <= '0;
			counter_overflow_flag <= 1'b0;
			adder_low_bit_cond <= 1'b0;
		end else begin
			if (run & uop.const_load)
				constant_field_reg <= const_value;
			if (taken & uop.addr_load)
				memory_address_reg <= constant_field_reg;
			if (cnt_load) begin
				loop_counter <= ~constant_field_reg;
				counter_overflow_flag <= 1'b0;
			end else if (cnt_inc) begin
				loop_counter <= count_sum[DATA_W-1:0];
				if (count_sum[DATA_W])
					counter_overflow_flag <= 1'b1;
			end
			if (run & uop.adder_used)
				adder_low_bit_cond <= adder_result[0];
		end
	end

	// Condition flags: a set in the clearing cycle wins
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			outside_event_flag <= 1'b0;
			shared_flag_one <= 1'b0;
			shared_flag_two <= 1'b0;
			private_flag_one <= 1'b0;
			private_flag_two <= 1'b0;
			private_flag_three <= 1'b0;
			read_complete_flag <= 1'b0;
		end else begin
			outside_event_flag <= outside_set | (outside_event_flag & ~tst_outside);
			shared_flag_one <= shared_flag_one | set_req[0];
			shared_flag_two <= shared_flag_two | set_req[1];
			private_flag_one <= set_req[2] | (private_flag_one & ~tst_priv1);
			private_flag_two <= set_req[3] | (private_flag_two & ~tst_priv2);
			private_flag_three <= set_req[4] | (private_flag_three & ~tst_priv3);
			read_complete_flag <= ready_set | (read_complete_flag & ~tst_ready);
		end
	end

	// Register bus: write taken once address and data are both present
	wire wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
	wire rd_take = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
	wire [7:0] wr_ofs = s_axi_awaddr[7:0];
	wire [7:0] rd_ofs = s_axi_araddr[7:0];
	wire wr_base = wr_take & (wr_ofs == `MCCU_OFS_BASE);
	wire wr_shift = wr_take & (wr_ofs == `MCCU_OFS_SHIFT);
	wire wr_mask = wr_take & (wr_ofs == `MCCU_OFS_MASK);
	wire wr_hit = (wr_ofs == `MCCU_OFS_BASE) | (wr_ofs == `MCCU_OFS_SHIFT) |
		(wr_ofs == `MCCU_OFS_MASK);
	wire rd_status = rd_take & (rd_ofs == `MCCU_OFS_STATUS);
	wire [3:0] st = s_axi_wstrb;

	logic [8:0] flag_view;
	always_comb begin
		flag_view = `MCCU_RST_FLAGS;
		flag_view[`MCCU_FLG_OUTSIDE] = outside_event_flag;
		flag_view[`MCCU_FLG_SHARED1] = shared_flag_one;
		flag_view[`MCCU_FLG_SHARED2] = shared_flag_two;
		flag_view[`MCCU_FLG_PRIV1] = private_flag_one;
		flag_view[`MCCU_FLG_PRIV2] = private_flag_two;
		flag_view[`MCCU_FLG_PRIV3] = private_flag_three;
		flag_view[`MCCU_FLG_READ_DONE] = read_complete_flag;
		flag_view[`MCCU_FLG_OVERFLOW] = counter_overflow_flag;
		flag_view[`MCCU_FLG_LOW_BIT] = adder_low_bit_cond;
	end

	logic [31:0] rd_word;
	logic rd_hit;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (rd_ofs)
			`MCCU_OFS_BASE: rd_word = {base_reg_two, base_reg_one};
			`MCCU_OFS_SHIFT: rd_word = 32'(shift_amount_reg);
			`MCCU_OFS_STATUS: rd_word = 32'(irq_status);
			`MCCU_OFS_MASK: rd_word = 32'(irq_mask);
			`MCCU_OFS_FLAGS: rd_word = 32'(flag_view);
			`MCCU_OFS_COUNT: rd_word = 32'({counter_overflow_flag, loop_counter});
			`MCCU_OFS_SEQ: rd_word = {4'h0, alternate_sequence_counter, 4'h0, sequence_counter};
			`MCCU_OFS_ADDR: rd_word = 32'(memory_address_reg);
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			base_reg_one <= 16'h0000;
			base_reg_two <= 16'h0000;
			shift_amount_reg <= '0;
			irq_mask <= `MCCU_RST_MASK;
		end else begin
			if (wr_base & st[0])
				base_reg_one[7:0] <= s_axi_wdata[7:0];
			if (wr_base & st[1])
				base_reg_one[15:8] <= s_axi_wdata[15:8];
			if (wr_base & st[2])
				base_reg_two[7:0] <= s_axi_wdata[23:16];
			if (wr_base & st[3])
				base_reg_two[15:8] <= s_axi_wdata[31:24];
			// Microcode complement load wins over a software write
			if (run & uop.shift_comp_load)
				shift_amount_reg <= ~shift_amount_reg;
			else if (wr_shift & st[0])
				shift_amount_reg <= s_axi_wdata[SHIFT_W-1:0];
			if (wr_mask & st[0])
				irq_mask <= s_axi_wdata[2:0];
		end
	end

	// Sticky events; a read clears, but a same-cycle event survives
	wire [2:0] irq_events = {outside_set, cnt_inc & count_sum[DATA_W], dev_irq_event};
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irq_status <= 3'h0;
			irq <= 1'b0;
		end else begin
			irq_status <= irq_events | (irq_status & {3{~rd_status}});
			irq <= |(irq_status & irq_mask);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MCCU_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `MCCU_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			s_axi_awready <= wr_take;
			s_axi_wready <= wr_take;
			if (wr_take) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `MCCU_RESP_OKAY : `MCCU_RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= rd_take;
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? `MCCU_RESP_OKAY : `MCCU_RESP_SLVERR;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// File: test/mccu_far_model.sv
module mccu_far_model (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic tick_req,
	input wire logic data_req,
	input wire logic [7:0] svc_req,
	output logic outside_event_pin,
	output logic read_ready_pin,
	output logic [7:0] dev_locked_pin,
	output logic [7:0] dev_service_pin,
	output logic [7:0] dev_selected
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] tick_len;
	logic [1:0] data_len;
	// Pulses last three cycles so the two-stage synchroniser cannot miss them
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tick_len <= '0;
			data_len <= '0;
		end else begin
			tick_len <= tick_req ? 2'h3 : tick_len - 2'(tick_len != 0);
			data_len <= data_req ? 2'h3 : data_len - 2'(data_len != 0);
		end
	end
	assign outside_event_pin = tick_len != 0;
	assign read_ready_pin = data_len != 0;
	// Devices three and five hold locks; only five is selected
	assign dev_locked_pin = 8'h28;
	assign dev_selected = 8'h20;
	assign dev_service_pin = svc_req;
endmodule

// File: test/mccu_top_assertions.sv
module mccu_top_chk import mccu_pkg::*; #(
	parameter int UADDR_W = 12
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic uop_valid,
	input wire mccu_uop_t uop,
	input wire logic [UADDR_W-1:0] alt_value,
	input wire logic [UADDR_W-1:0] next_uaddr,
	input wire logic branch_taken,
	input wire logic dev_read_stb,
	input wire logic dev_write_stb,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [UADDR_W-1:0] alt_q;
	logic shared_seen;
	wire logic plain_op = uop_valid && uop.test == MCCU_TST_NONE;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Mirror of the alternate counter, so sequencing is judged from ports alone
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			alt_q <= '0;
			shared_seen <= 1'h0;
		end else if (uop_valid) begin
			if (uop.alt_load)
				alt_q <= alt_value;
			if (uop.set_flags[0])
				shared_seen <= 1'h1;
		end
	end
	sequence priv_test;
		uop_valid && uop.test == MCCU_TST_PRIV1 && !uop.set_flags[2];
	endsequence
	AST_READ_STB: assert property (
		plain_op && uop.io inside {MCCU_IO_RD1, MCCU_IO_RD2} |=> dev_read_stb && !dev_write_stb)
		else $error("read strobe wrong");
	AST_WRITE_STB: assert property (
		plain_op && uop.io inside {MCCU_IO_WR1, MCCU_IO_WR2} |=> dev_write_stb && !dev_read_stb)
		else $error("write strobe wrong");
	AST_IDLE_STB: assert property (
		!uop_valid |=> !dev_read_stb && !dev_write_stb)
		else $error("strobe without instruction");
	AST_OUT_OF_SEQUENCE_OP: assert property (
		plain_op && uop.seq == MCCU_SEQ_OUT_OF_SEQUENCE_OP && !uop.alt_load |=> next_uaddr == $past(alt_q) + 1'h1)
		else $error("out-of-sequence address wrong");
	AST_JUMP: assert property (
		plain_op && uop.seq == MCCU_SEQ_JUMP && !uop.alt_load |=> next_uaddr == $past(alt_q) + 1'h1)
		else $error("jump address wrong");
	AST_SHARED_KEEP: assert property (
		uop_valid && uop.test == MCCU_TST_SHARED1 && shared_seen |=> branch_taken)
		else $error("shared flag lost");
	AST_PRIV_HIT: assert property (
		uop_valid && uop.set_flags[2] ##1 !uop_valid ##1 priv_test |=> branch_taken)
		else $error("private flag not seen");
	AST_PRIV_CLR: assert property (
		priv_test ##1 !uop_valid ##1 priv_test |=> !branch_taken)
		else $error("private flag not cleared");
	AST_AXI_WRITE: assert property (
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
		else $error("write not answered");
	AST_AXI_READ: assert property (
		s_axi_arvalid && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
		else $error("read not answered");
	cover property (plain_op && uop.seq == MCCU_SEQ_JUMP);
	cover property (priv_test);
	cover property (s_axi_bvalid && s_axi_wready);
endmodule

bind mccu_top mccu_top_chk #(.UADDR_W(UADDR_W)) chk (.*);

// File: test/testbench.sv
`include "mccu_defs.svh"
module testbench import mccu_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'h0, reset = 1'h1, uop_valid = 1'h0;
	mccu_uop_t uop = '0;
	mccu_uop_t u;
	logic [15:0] const_value = '0, adder_result = '0;
	logic [11:0] alt_value = '0;
	logic tick_req = 1'h0, data_req = 1'h0;
	logic [7:0] svc_req = '0;
	logic outside_event_pin, read_ready_pin, irq, branch_taken, dev_read_stb, dev_write_stb;
	logic [7:0] dev_locked_pin, dev_service_pin, dev_selected;
	logic [11:0] next_uaddr;
	logic [15:0] dev_base, shifter_out, adder_operand, memory_address_reg;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, r;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	int failures = 0, num_checks = 0, cyc = 0;

	mccu_top uut (.*);
	mccu_far_model far (.*);

	initial forever #12.5 clk_sys = ~clk_sys;

	task final_report;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			final_report();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task op(input mccu_uop_t v);
		@(posedge clk_sys);
		uop <= v;
		uop_valid <= 1'h1;
		@(posedge clk_sys);
		uop_valid <= 1'h0;
		#1;
	endtask

	// Address and data are offered together and answered together
	task wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do @(posedge clk_sys); while (!(s_axi_awready && s_axi_wready));
		{s_axi_awvalid, s_axi_wvalid} <= 2'h0;
		while (!s_axi_bvalid) @(posedge clk_sys);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task rd(input logic [31:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge clk_sys);
		r = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task t_reset;
		rd(`MCCU_OFS_FLAGS);
		chk(r, 32'h0000_0000);
		chk(rsp, `MCCU_RESP_OKAY);
		wr(`MCCU_OFS_FLAGS, 32'hffff_ffff);
		chk(rsp, `MCCU_RESP_SLVERR);
		rd(32'h0000_0040);
		chk(rsp, `MCCU_RESP_SLVERR);
		$display("reset test done");
	endtask

	task t_io;
		wr(`MCCU_OFS_BASE, 32'h2222_1111);
		chk(rsp, `MCCU_RESP_OKAY);
		u = '0;
		for (int i = 1; i < 5; i++) begin
			u.io = mccu_io_t'(i);
			op(u);
			chk({dev_read_stb, dev_write_stb}, i < 3 ? 2'h2 : 2'h1);
			chk(dev_base, i[0] ? 16'h1111 : 16'h2222);
		end
		$display("device test done");
	endtask

	task t_seq;
		u = '0;
		u.alt_load = 1'h1;
		alt_value <= 12'h005;
		op(u);
		u = '0;
		for (int i = 0; i < 2; i++) begin
			// Out-of-sequence first, so a wrongly advanced counter shows up
			u.seq = i ? MCCU_SEQ_JUMP : MCCU_SEQ_OUT_OF_SEQUENCE_OP;
			op(u);
			chk(next_uaddr, 12'h006);
			rd(`MCCU_OFS_SEQ);
			chk(r, i ? 32'h0005_0006 : 32'h0005_0005);
		end
		$display("sequence test done");
	endtask

	task t_count;
		u = '0;
		u.const_load = 1'h1;
		op(u);
		u = '0;
		u.cnt = MCCU_CNT_LOAD;
		op(u);
		rd(`MCCU_OFS_COUNT);
		chk(r, 32'h0000_ffff);
		wr(`MCCU_OFS_MASK, 32'h0000_0002);
		u.cnt = MCCU_CNT_INC;
		op(u);
		rd(`MCCU_OFS_COUNT);
		chk(r, 32'h0001_0000);
		chk(irq, 1'h1);
		rd(`MCCU_OFS_STATUS);
		chk(r, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		#1;
		chk(irq, 1'h0);
		u.cnt = MCCU_CNT_LOAD;
		op(u);
		rd(`MCCU_OFS_COUNT);
		chk(r, 32'h0000_ffff);
		$display("counter test done");
	endtask

	task t_data;
		u = '0;
		u.const_load = 1'h1;
		const_value <= 16'h1234;
		op(u);
		u = '0;
		u.addr_load = 1'h1;
		op(u);
		chk(memory_address_reg, 16'h1234);
		chk(adder_operand, 16'h1234);
		wr(`MCCU_OFS_SHIFT, 32'h0000_0001);
		for (int i = 0; i < 2; i++) begin
			adder_result <= i ? 16'h8000 : 16'h8001;
			u = '0;
			u.shift_left = 1'h1;
			u.adder_used = 1'h1;
			op(u);
			chk(shifter_out, i ? 16'h0000 : 16'h0002);
			u = '0;
			u.test = MCCU_TST_LOW_BIT;
			op(u);
			chk(branch_taken, i == 0);
		end
		u = '0;
		u.shift_comp_load = 1'h1;
		op(u);
		rd(`MCCU_OFS_SHIFT);
		chk(r, 32'h0000_000e);
		u = '0;
		u.adder_src = MCCU_SRC_SHIFT_COMP;
		op(u);
		chk(adder_operand, 16'h0001);
		u.adder_src = MCCU_SRC_COUNTER;
		op(u);
		chk(adder_operand, 16'hffff);
		$display("data path test done");
	endtask

	task t_flags;
		for (int i = 0; i < 5; i++) begin
			u = '0;
			u.set_flags = 5'h01 << i;
			op(u);
			u = '0;
			u.test = mccu_test_t'(i + 2);
			op(u);
			chk(branch_taken, 1'h1);
			op(u);
			chk(branch_taken, i < 2);
		end
		for (int j = 0; j < 2; j++) begin
			{data_req, tick_req} <= j ? 2'h2 : 2'h1;
			@(posedge clk_sys);
			{data_req, tick_req} <= 2'h0;
			repeat (6) @(posedge clk_sys);
			u.test = j ? MCCU_TST_READ_DONE : MCCU_TST_OUTSIDE;
			op(u);
			chk(branch_taken, 1'h1);
			op(u);
			chk(branch_taken, 1'h0);
		end
		$display("flag test done");
	endtask

	// A selected device asking for service must stay quiet
	task t_irq;
		rd(`MCCU_OFS_STATUS);
		wr(`MCCU_OFS_MASK, 32'h0000_0000);
		// Unselected locked, selected locked, then unselected but unlocked
		for (int k = 0; k < 3; k++) begin
			svc_req <= k == 0 ? 8'h08 : (k == 1 ? 8'h20 : 8'h01);
			repeat (6) @(posedge clk_sys);
			#1;
			chk(irq, 1'h0);
			wr(`MCCU_OFS_MASK, 32'h0000_0001);
			repeat (2) @(posedge clk_sys);
			#1;
			chk(irq, k == 0);
			svc_req <= 8'h00;
			repeat (6) @(posedge clk_sys);
			rd(`MCCU_OFS_STATUS);
			chk(r, k == 0);
			wr(`MCCU_OFS_MASK, 32'h0000_0000);
		end
		$display("interrupt test done");
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'h0;
		t_reset();
		t_io();
		t_seq();
		t_count();
		t_data();
		t_flags();
		t_irq();
		final_report();
	end
endmodule
